// [core/pbcs_params.svh]
`ifndef PBCS_PARAMS_SVH
`define PBCS_PARAMS_SVH
// Clock period of the system clock in ns
`define PBCS_CLK_NS          8
// Power-on reset delay, default the 12 ms minimum
`define PBCS_POR_MS          12
`define PBCS_POR_CYC         (`PBCS_POR_MS * 1000000 / `PBCS_CLK_NS)
// Status low pulse during reconfiguration reset, 10 us least
`define PBCS_STATUS_US       10
`define PBCS_STATUS_CYC \
  ((`PBCS_STATUS_US * 1000 + `PBCS_CLK_NS - 1) / `PBCS_CLK_NS)
// Error reset timeout with auto-restart, 40 us most
`define PBCS_ERR_US          40
`define PBCS_ERR_CYC         (`PBCS_ERR_US * 1000 / `PBCS_CLK_NS)
// Done high to user mode on internal oscillator, 20 us least
`define PBCS_UM_US           20
`define PBCS_UM_CYC \
  ((`PBCS_UM_US * 1000 + `PBCS_CLK_NS - 1) / `PBCS_CLK_NS)
// Load clock periods before the user start-up clock is enabled
`define PBCS_USR_EN_LCLK     4
// Minimum load clock period in ns (10 ns least period)
`define PBCS_LCLK_NS         10
`define PBCS_USR_EN_CYC \
  ((`PBCS_USR_EN_LCLK * `PBCS_LCLK_NS + `PBCS_CLK_NS - 1) / `PBCS_CLK_NS)
// User start-up clock periods before user mode
`define PBCS_USR_PERIODS     299
// Default number of configuration bytes
`define PBCS_IMAGE_BYTES     1024
`define PBCS_CNT_W           32
`endif

// [core/pbcs_pkg.sv]
`default_nettype none
package pbcs_pkg;
  typedef enum logic [2:0] {
    ST_POR, ST_RESET, ST_WAIT_REQ, ST_LOAD, ST_ERROR, ST_INIT, ST_USER
  } pbcs_state_t;
endpackage
`default_nettype wire

// [core/pbcs_top.sv]
`timescale 1ns/1ns
`default_nettype none
`include "pbcs_params.svh"
// Function
// - In user mode lines stay high; request low starts reconfiguration.
// - Status held low for the full power-on reset delay.
// - Done held low from power-up until all data accepted.
// - Done pulled low within 800 ns of request falling.
// - Status pulled low within 800 ns of request falling.
// - Reconfiguration reset holds status low 10 to 100 us.
// - Status released within 100 us after request returns high.
// - Internal oscillator start-up: user mode 20 to 40 us after done.
// - User clock enabled 4 load periods after done, user mode 299 later.
// - One byte captured on every rising load clock edge.
// - Error pulls status low; auto-restart releases within 40 us.
// - Done released high once all data received correctly.
module pbcs_top #(
  parameter int unsigned POR_CYC    = `PBCS_POR_CYC,
  parameter int unsigned ERR_CYC    = `PBCS_ERR_CYC,
  parameter int unsigned UM_CYC     = `PBCS_UM_CYC,
  parameter int unsigned IMAGE_BYTES = `PBCS_IMAGE_BYTES
) (
  input  wire logic       CLK,
  input  wire logic       ARST_N,
  input  wire logic       LOAD_CLOCK,
  input  wire logic [7:0] LOAD_DATA,
  input  wire logic       REQUEST_N,
  input  wire logic       ERROR_FLAG_N_IN,
  output logic            ERROR_FLAG_N_OE,
  output logic            ERROR_FLAG_N_OUT,
  input  wire logic       DONE_IN,
  output logic            DONE_OE,
  output logic            DONE_OUT,
  input  wire logic       USER_STARTUP_CLOCK,
  input  wire logic       USE_STARTUP_CLOCK,
  input  wire logic       AUTO_RESTART,
  input  wire logic       CRC_OK,
  output logic            USER_MODE,
  output logic            STARTUP_CLOCK_EN,
  output logic [7:0]      BYTE_DATA,
  output logic            BYTE_VALID
);

  // Link-domain state: byte capture and toggle event
  typedef struct packed {
    logic [7:0] byte_r;
    logic       tgl_r;
  } pbcs_link_t;

  // System-domain state
  typedef struct packed {
    pbcs_pkg::pbcs_state_t   st_r;
    logic [`PBCS_CNT_W-1:0]  cnt_r;
    logic [`PBCS_CNT_W-1:0]  bytes_r;
    logic                    usr_en_r;
    logic [1:0]              req_s_r;
    logic [1:0]              stat_s_r;
    logic [1:0]              arm_s_r;
    logic [2:0]              tgl_s_r;
    logic [7:0]              data_r;
    logic                    valid_r;
    logic [2:0]              opt_a_r;
    logic [2:0]              opt_b_r;
    logic [2:0]              ud_s_r;
  } pbcs_sys_t;

  // User clock domain: counts periods once enabled
  typedef struct packed {
    logic [1:0] en_s_r;
    logic [8:0] cnt_r;
    logic       tgl_r;
  } pbcs_usr_t;

  pbcs_link_t lk_r, lk_nxt;
  pbcs_sys_t  sy_r, sy_nxt;
  pbcs_usr_t  us_r, us_nxt;

  // byte capture on every rise
  // Link clock is parked between frames, so no arming flops here;
  // the system side drops events that arrive outside loading
  always_comb begin
    lk_nxt        = lk_r;
    lk_nxt.byte_r = LOAD_DATA;
    lk_nxt.tgl_r  = ~lk_r.tgl_r;
  end

  // Link-domain register
  always_ff @(posedge LOAD_CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // User start-up clock counter
  always_comb begin
    us_nxt        = us_r;
    us_nxt.en_s_r = {us_r.en_s_r[0], sy_r.usr_en_r};
    us_nxt.tgl_r  = 1'b0;
    if (!us_r.en_s_r[1]) begin
      us_nxt.cnt_r = '0;
    end else if (us_r.cnt_r != 9'(`PBCS_USR_PERIODS)) begin
      us_nxt.cnt_r = us_r.cnt_r + 9'h001;
    end else begin
      us_nxt.tgl_r = 1'b1;
    end
  end

  // User clock register
  always_ff @(posedge USER_STARTUP_CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      us_r <= '0;
    end else begin
      us_r <= us_nxt;
    end
  end

  // Main sequencer
  always_comb begin
    logic req_lo;
    logic byte_ev;
    req_lo         = 1'b0;
    byte_ev        = 1'b0;
    sy_nxt         = sy_r;
    sy_nxt.req_s_r = {sy_r.req_s_r[0], REQUEST_N};
    sy_nxt.stat_s_r = {sy_r.stat_s_r[0], ERROR_FLAG_N_IN};
    sy_nxt.tgl_s_r = {sy_r.tgl_s_r[1:0], lk_r.tgl_r};
    // Option pins through two flops: [2] user clock, [1] restart, [0] good
    sy_nxt.opt_a_r = {USE_STARTUP_CLOCK, AUTO_RESTART, CRC_OK};
    sy_nxt.opt_b_r = sy_r.opt_a_r;
    sy_nxt.ud_s_r  = {sy_r.ud_s_r[1:0], us_r.tgl_r}; // User-clock done
    sy_nxt.valid_r = 1'b0;
    req_lo         = !sy_r.req_s_r[1];
    byte_ev        = sy_r.tgl_s_r[2] ^ sy_r.tgl_s_r[1];
    if (sy_r.cnt_r != '0) begin
      sy_nxt.cnt_r = sy_r.cnt_r - `PBCS_CNT_W'(1);
    end
    unique case (sy_r.st_r)
      pbcs_pkg::ST_POR: begin
        if (sy_r.cnt_r == '0) begin
          sy_nxt.st_r = pbcs_pkg::ST_WAIT_REQ;
        end
      end
      // minimum reset pulse, extended by request low
      pbcs_pkg::ST_RESET: begin
        if (req_lo) begin
          sy_nxt.cnt_r = `PBCS_CNT_W'(`PBCS_STATUS_CYC);
        end else if (sy_r.cnt_r == '0) begin
          sy_nxt.st_r = pbcs_pkg::ST_WAIT_REQ;
        end
      end
      // status released; wait for line high then load
      pbcs_pkg::ST_WAIT_REQ: begin
        if (req_lo) begin
          sy_nxt.st_r  = pbcs_pkg::ST_RESET;
          sy_nxt.cnt_r = `PBCS_CNT_W'(`PBCS_STATUS_CYC);
        end else if (sy_r.stat_s_r[1]) begin
          sy_nxt.st_r    = pbcs_pkg::ST_LOAD;
          sy_nxt.bytes_r = '0;
        end
      end
      // bytes counted; error on bad image
      pbcs_pkg::ST_LOAD: begin
        if (req_lo) begin
          sy_nxt.st_r  = pbcs_pkg::ST_RESET;
          sy_nxt.cnt_r = `PBCS_CNT_W'(`PBCS_STATUS_CYC);
        end else if (byte_ev) begin
          sy_nxt.data_r  = lk_r.byte_r;
          sy_nxt.valid_r = 1'b1;
          sy_nxt.bytes_r = sy_r.bytes_r + `PBCS_CNT_W'(1);
          if (sy_r.bytes_r == `PBCS_CNT_W'(IMAGE_BYTES - 1)) begin
            if (sy_r.opt_b_r[0]) begin
              sy_nxt.st_r  = pbcs_pkg::ST_INIT;
              sy_nxt.cnt_r = sy_r.opt_b_r[2]
                ? `PBCS_CNT_W'(`PBCS_USR_EN_CYC)
                : `PBCS_CNT_W'(UM_CYC);
            end else begin
              sy_nxt.st_r  = pbcs_pkg::ST_ERROR;
              sy_nxt.cnt_r = `PBCS_CNT_W'(ERR_CYC);
            end
          end
        end
      end
      pbcs_pkg::ST_ERROR: begin
        if (req_lo) begin
          sy_nxt.st_r  = pbcs_pkg::ST_RESET;
          sy_nxt.cnt_r = `PBCS_CNT_W'(`PBCS_STATUS_CYC);
        end else if (sy_r.opt_b_r[1] && sy_r.cnt_r == '0) begin
          sy_nxt.st_r = pbcs_pkg::ST_WAIT_REQ;
        end
      end
      pbcs_pkg::ST_INIT: begin
        if (req_lo) begin
          sy_nxt.st_r     = pbcs_pkg::ST_RESET;
          sy_nxt.usr_en_r = 1'b0;
          sy_nxt.cnt_r    = `PBCS_CNT_W'(`PBCS_STATUS_CYC);
        end else if (sy_r.opt_b_r[2]) begin
          if (sy_r.cnt_r == '0) begin
            sy_nxt.usr_en_r = 1'b1;
          end
          if (sy_r.ud_s_r[2]) begin
            sy_nxt.st_r = pbcs_pkg::ST_USER;
          end
        end else if (sy_r.cnt_r == '0) begin
          sy_nxt.st_r = pbcs_pkg::ST_USER;
        end
      end
      pbcs_pkg::ST_USER: begin
        if (req_lo) begin
          sy_nxt.st_r     = pbcs_pkg::ST_RESET;
          sy_nxt.usr_en_r = 1'b0;
          sy_nxt.cnt_r    = `PBCS_CNT_W'(`PBCS_STATUS_CYC);
        end
      end
      default: begin
        sy_nxt.st_r = pbcs_pkg::ST_POR;
      end
    endcase
  end

  // System register
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sy_r       <= '0;
      sy_r.st_r  <= pbcs_pkg::ST_POR;
      sy_r.cnt_r <= `PBCS_CNT_W'(POR_CYC);
    end else begin
      sy_r <= sy_nxt;
    end
  end

  assign ERROR_FLAG_N_OUT = 1'b0;
  assign ERROR_FLAG_N_OE  = (sy_r.st_r == pbcs_pkg::ST_POR)
                         || (sy_r.st_r == pbcs_pkg::ST_RESET)
                         || (sy_r.st_r == pbcs_pkg::ST_ERROR);
  assign DONE_OUT         = 1'b0;
  assign DONE_OE          = (sy_r.st_r != pbcs_pkg::ST_INIT)
                         && (sy_r.st_r != pbcs_pkg::ST_USER);
  assign USER_MODE        = (sy_r.st_r == pbcs_pkg::ST_USER);
  assign STARTUP_CLOCK_EN = sy_r.usr_en_r;
  assign BYTE_DATA        = sy_r.data_r;
  assign BYTE_VALID       = sy_r.valid_r;

endmodule
`default_nettype wire

// [verif/pbcs_asserts.sv]
`timescale 1ns/1ns
`default_nettype none
module pbcs_asserts #(
  parameter int unsigned POR_CYC     = 100,
  parameter int unsigned UM_CYC      = 30,
  parameter int unsigned IMAGE_BYTES = 8
) (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REQUEST_N,
  input wire logic USE_STARTUP_CLOCK,
  input wire logic ERROR_FLAG_N_OE,
  input wire logic DONE_OE,
  input wire logic USER_MODE,
  input wire logic STARTUP_CLOCK_EN,
  input wire logic BYTE_VALID
);
  int unsigned pc, sc, hc, uc, nb;
  logic        rq;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // Cycle and byte counters behind the timed checks
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {pc, sc, hc, uc, nb} <= '0;
      rq <= 1'b0;
    end else begin
      pc <= (pc < POR_CYC) ? pc + 32'h1 : pc;
      sc <= ERROR_FLAG_N_OE ? sc + 32'h1 : '0;
      hc <= (rq && REQUEST_N && ERROR_FLAG_N_OE) ? hc + 32'h1 : '0;
      uc <= (!DONE_OE && !USER_MODE) ? uc + 32'h1 : '0;
      nb <= REQUEST_N ? nb + 32'(BYTE_VALID) : '0;
      rq <= !REQUEST_N || (rq && ERROR_FLAG_N_OE);
    end
  end
  sequence req_fall; $fell(REQUEST_N); endsequence
  sequence done_up; $fell(DONE_OE) && USE_STARTUP_CLOCK; endsequence
  por_hold_a: assert property (pc < POR_CYC |-> ERROR_FLAG_N_OE)
    else $error("status freed in power-on delay");
  req_status_a: assert property (req_fall |-> ##[0:100] ERROR_FLAG_N_OE)
    else $error("status late after request");
  req_done_a: assert property (req_fall |-> ##[0:100] DONE_OE)
    else $error("done late after request");
  user_lines_a: assert property (
    USER_MODE |-> !ERROR_FLAG_N_OE && !DONE_OE)
    else $error("lines low in user mode");
  done_count_a: assert property (
    $fell(DONE_OE) |-> nb + 32'(BYTE_VALID) == IMAGE_BYTES)
    else $error("done freed at wrong byte count");
  status_min_a: assert property (
    $fell(ERROR_FLAG_N_OE) && rq |-> sc >= 1250)
    else $error("status low too short");
  status_rel_a: assert property (hc <= 12500)
    else $error("status held too long");
  user_time_a: assert property (
    $rose(USER_MODE) && !USE_STARTUP_CLOCK |->
    uc + 1 >= UM_CYC && uc <= 2 * UM_CYC)
    else $error("user mode entry off time");
  clk_en_a: assert property (done_up |-> ##[1:8] STARTUP_CLOCK_EN)
    else $error("start-up clock not enabled");
endmodule
`default_nettype wire

// [verif/pbcs_host.sv]
`timescale 1ns/1ns
`default_nettype none
module pbcs_host (
  input  wire logic       CLK,
  input  wire logic       STATUS_N,
  output var  logic       REQUEST_N,
  output var  logic       LOAD_CLOCK,
  output var  logic [7:0] LOAD_DATA
);
  initial begin
    REQUEST_N = 1'b1;
    LOAD_CLOCK = 1'b0;
    LOAD_DATA = 8'h5A;
  end
  task automatic restart();
    REQUEST_N <= 1'b0;
    repeat (250) @(posedge CLK);
    REQUEST_N <= 1'b1;
    repeat (12500) @(posedge CLK);
    for (int n = 0; n < 5000 && STATUS_N !== 1'b1; n++) @(posedge CLK);
    repeat (250) @(posedge CLK);
  endtask
  task automatic send(input logic [7:0] b);
    LOAD_DATA <= b;
    #31 LOAD_CLOCK <= 1'b1;
    #63 LOAD_CLOCK <= 1'b0;
    LOAD_DATA <= ~b;
    #31;
  endtask
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        clk, arst_n, use_uclk, auto_rst, crc_ok;
  logic        lclk, req_n, st_oe, dn_oe, um, bv, st_o, dn_o, suen;
  logic        uclk = 1'b0;
  logic [7:0]  ldata, bdata;
  logic [7:0]  got[$];
  logic [31:0] seed = 32'h32A226C6;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  pbcs_top #(.POR_CYC(100), .ERR_CYC(50), .UM_CYC(30), .IMAGE_BYTES(8)) dut (
    .CLK(clk), .ARST_N(arst_n), .LOAD_CLOCK(lclk), .LOAD_DATA(ldata),
    .REQUEST_N(req_n), .ERROR_FLAG_N_IN(!st_oe), .ERROR_FLAG_N_OE(st_oe),
    .ERROR_FLAG_N_OUT(st_o), .DONE_IN(!dn_oe), .DONE_OE(dn_oe),
    .DONE_OUT(dn_o),
    .USER_STARTUP_CLOCK(uclk), .USE_STARTUP_CLOCK(use_uclk),
    .AUTO_RESTART(auto_rst), .CRC_OK(crc_ok), .USER_MODE(um),
    .STARTUP_CLOCK_EN(suen), .BYTE_DATA(bdata), .BYTE_VALID(bv));
  pbcs_host host (.CLK(clk), .STATUS_N(!st_oe), .REQUEST_N(req_n),
    .LOAD_CLOCK(lclk), .LOAD_DATA(ldata));
  // System clock and user start-up clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always #20 uclk = ~uclk;
  // Collect bytes and cut a hung run short
  always @(posedge clk) begin
    if (bv === 1'b1) got.push_back(bdata);
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      miscompares++;
      end_sim();
    end
  end
  // Next stimulus value
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Compare and count
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  // Counts, verdict, stop
  task automatic end_sim();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One image with extreme first and last bytes, then outcome checks
  task automatic run(input logic ok, input logic usr, input logic ar);
    logic [7:0] exp[$];
    crc_ok <= ok;
    use_uclk <= usr;
    auto_rst <= ar;
    host.restart();
    got.delete();
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      exp.push_back(i == 0 ? 8'h00 : (i == 7 ? 8'hFF : seed[7:0]));
      host.send(exp[i]);
    end
    repeat (20) @(posedge clk);
    check(8'(got.size()), 8'h08);
    foreach (exp[i]) check(got[i], exp[i]);
    check(8'(dn_oe), 8'(!ok));
    check(8'(st_oe), 8'(!ok));
    check(8'({st_o, dn_o}), 8'h00);
    repeat (2000) @(posedge clk);
    check(8'(um), 8'(ok));
    check(8'(suen), 8'(ok && usr));
    check(8'(st_oe), 8'(!ok && !ar));
  endtask
  // Reset, then good, failed and start-up clock images
  initial begin
    {arst_n, use_uclk, auto_rst, crc_ok} = 4'h0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (200) @(posedge clk);
    run(1'b1, 1'b0, 1'b1);
    run(1'b0, 1'b0, 1'b1);
    run(1'b0, 1'b0, 1'b0);
    run(1'b1, 1'b1, 1'b1);
    end_sim();
  end
endmodule
bind pbcs_top pbcs_asserts #(.POR_CYC(POR_CYC), .UM_CYC(UM_CYC),
  .IMAGE_BYTES(IMAGE_BYTES)) chk (.CLK, .ARST_N, .REQUEST_N,
  .USE_STARTUP_CLOCK, .ERROR_FLAG_N_OE, .DONE_OE, .USER_MODE,
  .STARTUP_CLOCK_EN, .BYTE_VALID);
`default_nettype wire
